// ===== hw/ssje_decode.sv
`include "ssje_map.svh"
module ssje_decode
  import ssje_pkg::*;
(
  // Opcode in
  input  wire logic [7:0] opcode,
  // Decoded class
  output ssje_op_e        op_class,
  output logic [2:0]      op_cycles,
  output logic [1:0]      op_bytes
);

  // Pattern match; unknown opcodes give none
  always_comb begin
    op_class  = SSJE_NONE;
    op_cycles = `SSJE_CYC_ONE;
    op_bytes  = 2'h1;
    if ((opcode & `SSJE_MASK_PULL) == `SSJE_OP_PULL) begin
      op_class  = SSJE_PULL;
      op_cycles = `SSJE_CYC_TWO;
      op_bytes  = 2'h2;
    end else if ((opcode & `SSJE_MASK_SWAPD) == `SSJE_OP_SWAPD) begin
      op_class = SSJE_SWAPD;
      op_bytes = 2'h2;
    end else if ((opcode & `SSJE_MASK_SWAPI) == `SSJE_OP_SWAPI) begin
      op_class = SSJE_SWAPI;
    end else if ((opcode & `SSJE_MASK_NEAR) == `SSJE_OP_NEAR) begin
      op_class  = SSJE_NEAR;
      op_cycles = `SSJE_CYC_TWO;
      op_bytes  = 2'h2;
    end else if (opcode == `SSJE_OP_FAR) begin
      op_class  = SSJE_FAR;
      op_cycles = `SSJE_CYC_TWO;
      op_bytes  = 2'h3;
    end else if (opcode == `SSJE_OP_SHORT) begin
      op_class  = SSJE_SHORT;
      op_cycles = `SSJE_CYC_TWO;
      op_bytes  = 2'h2;
    end else if (opcode == `SSJE_OP_LONG) begin
      op_class  = SSJE_LONG;
      op_cycles = `SSJE_CYC_FOUR;
      op_bytes  = 2'h3;
    end
  end

endmodule : ssje_decode

// ===== hw/ssje_exec.sv
`include "ssje_map.svh"
module ssje_exec
  import ssje_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Instruction bytes, presented with start
  input  wire logic        start,
  input  wire logic [7:0]  instr_b0,
  input  wire logic [7:0]  instr_b1,
  input  wire logic [7:0]  instr_b2,
  // Work register and indirect pointer contents
  input  wire logic [7:0]  work_reg_in,
  input  wire logic [8:0]  indirect_ptr_val,
  // Data read return
  input  wire logic [7:0]  data_rd,
  // Data memory access
  output logic [8:0]       data_addr,
  output logic             data_bank0,
  output logic             data_rd_en,
  output logic             data_wr_en,
  output logic [7:0]       data_wr,
  // Work register update
  output logic             work_reg_we,
  output logic [7:0]       work_reg_out,
  // Indirect pointer select for the core
  output logic [1:0]       indirect_pointer_select,
  // Architectural state
  output logic [15:0]      program_counter,
  output logic [7:0]       stack_ptr,
  // Status
  output logic             busy,
  output logic             done,
  output logic             irq_window,
  output logic             flags_we,
  output logic             illegal_op
);

  // ************************************************
  // Decode
  // ************************************************
  ssje_op_e   dec_class;
  logic [2:0] dec_cycles;
  logic [1:0] dec_bytes;

  ssje_decode u_decode (
    .opcode    (instr_b0),
    .op_class  (dec_class),
    .op_cycles (dec_cycles),
    .op_bytes  (dec_bytes)
  );

  // ************************************************
  // State
  // ************************************************
  ssje_op_e    op_ff,       nxt_op;
  logic [2:0]  cyc_ff,      nxt_cyc;
  logic [2:0]  last_ff,     nxt_last;
  logic [7:0]  b0_ff,       nxt_b0;
  logic [7:0]  b1_ff,       nxt_b1;
  logic [7:0]  b2_ff,       nxt_b2;
  logic [15:0] pc_ff,       nxt_pc;
  logic [7:0]  sp_ff,       nxt_sp;
  logic [8:0]  addr_ff,     nxt_addr;
  logic        bank0_ff,    nxt_bank0;
  logic        rd_ff,       nxt_rd;
  logic        wr_ff,       nxt_wr;
  logic [7:0]  wdat_ff,     nxt_wdat;
  logic        wwe_ff,      nxt_wwe;
  logic [7:0]  wdout_ff,    nxt_wdout;
  logic [1:0]  psel_ff,     nxt_psel;
  logic        done_ff,     nxt_done;
  logic        irq_ff,      nxt_irq;
  logic        ill_ff,      nxt_ill;

  // Targets computed from captured bytes
  logic [15:0] pc_plus2;
  logic [15:0] pc_plus3;
  logic [15:0] near_target;
  logic [15:0] far_target;
  logic [15:0] short_displacement;
  logic [15:0] long_displacement;
  logic [8:0]  direct_operand;

  // Address arithmetic, counter targets kept at 16 bits so wrap is natural; direct operand is 9 bits
  always_comb begin
    pc_plus2           = pc_ff + `SSJE_PC_STEP2;
    pc_plus3           = pc_ff + `SSJE_PC_STEP3;
    // keep upper bits of advanced counter
    near_target        = {pc_plus2[15:12], b0_ff[`SSJE_A11_BIT], b0_ff[2:0], b1_ff};
    far_target         = {b1_ff, b2_ff};
    short_displacement = {{8{b1_ff[7]}}, b1_ff};
    long_displacement  = {b2_ff, b1_ff};
    direct_operand     = {b0_ff[`SSJE_D8_BIT], b1_ff};
  end

  // ************************************************
  // Sequencer next state
  // ************************************************
  always_comb begin
    nxt_op    = op_ff;
    nxt_cyc   = cyc_ff;
    nxt_last  = last_ff;
    nxt_b0    = b0_ff;
    nxt_b1    = b1_ff;
    nxt_b2    = b2_ff;
    nxt_pc    = pc_ff;
    nxt_sp    = sp_ff;
    nxt_addr  = addr_ff;
    nxt_bank0 = 1'b0;
    nxt_rd    = 1'b0;
    nxt_wr    = 1'b0;
    nxt_wdat  = wdat_ff;
    nxt_wwe   = 1'b0;
    nxt_wdout = wdout_ff;
    nxt_psel  = psel_ff;
    nxt_done  = 1'b0;
    nxt_irq   = 1'b0;
    nxt_ill   = 1'b0;
    if (op_ff == SSJE_NONE) begin
      // Idle: capture a new instruction; ignored while busy
      if (start) begin
        nxt_b0   = instr_b0;
        nxt_b1   = instr_b1;
        nxt_b2   = instr_b2;
        nxt_op   = dec_class;
        // Swaps need a read edge and a write edge, so never fewer than two;
        // the read data only returns one cycle after its strobe
        nxt_last = (dec_cycles < `SSJE_CYC_TWO) ? `SSJE_CYC_TWO : dec_cycles;
        nxt_cyc  = `SSJE_CYC_ONE;
        nxt_psel = instr_b0[1:0];
        nxt_ill  = (dec_class == SSJE_NONE);
        case (dec_class)
          // stack read forced to bank 0
          SSJE_PULL: begin
            nxt_addr  = {1'b0, sp_ff};
            nxt_bank0 = 1'b1;
            nxt_rd    = 1'b1;
          end
          SSJE_SWAPD: begin
            nxt_addr = {instr_b0[`SSJE_D8_BIT], instr_b1};
            nxt_rd   = 1'b1;
          end
          SSJE_SWAPI: begin
            nxt_addr = indirect_ptr_val;
            nxt_rd   = 1'b1;
          end
          default: begin
            nxt_addr = addr_ff;
          end
        endcase
      end
    end else begin
      nxt_cyc = cyc_ff + `SSJE_CYC_ONE;
      // Nothing lands before the last cycle: the read strobed at take time
      // returns one cycle late, and a counter or pointer stepped early would
      // be stepped a second time on the next pass through here
      if (cyc_ff == last_ff) begin
        nxt_op   = SSJE_NONE;
        nxt_done = 1'b1;
        // interrupt window on the last cycle of every instruction (fourth for long branch)
        nxt_irq  = 1'b1;
        case (op_ff)
          // write stack byte to operand, then decrement
          SSJE_PULL: begin
            nxt_addr = direct_operand;
            nxt_wr   = 1'b1;
            nxt_wdat = data_rd;
            nxt_sp   = sp_ff - 8'h01;
            nxt_pc   = pc_plus2;
          end
          // exchange with direct byte
          // Old byte to the work register, old work value back to memory
          SSJE_SWAPD: begin
            nxt_wr    = 1'b1;
            nxt_wdat  = work_reg_in;
            nxt_wwe   = 1'b1;
            nxt_wdout = data_rd;
            nxt_pc    = pc_plus2;
          end
          // exchange with pointed byte
          // Same exchange; address was latched from the pointer at take
          SSJE_SWAPI: begin
            nxt_wr    = 1'b1;
            nxt_wdat  = work_reg_in;
            nxt_wwe   = 1'b1;
            nxt_wdout = data_rd;
            nxt_pc    = pc_ff + `SSJE_PC_STEP1;
          end
          // upper bits kept from advanced counter
          SSJE_NEAR: begin
            nxt_pc = near_target;
          end
          SSJE_FAR: begin
            nxt_pc = far_target;
          end
          // signed short displacement
          // Sign extension lets the hop run backwards
          SSJE_SHORT: begin
            nxt_pc = pc_plus2 + short_displacement;
          end
          // plus three, minus one, plus displacement
          // Carry out of bit 15 is dropped: the counter wraps
          SSJE_LONG: begin
            nxt_pc = pc_plus3 - `SSJE_PC_STEP1 + long_displacement;
          end
          default: begin
            nxt_pc = pc_ff;
          end
        endcase
      end
    end
  end

  // Register the sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      op_ff    <= SSJE_NONE;
      cyc_ff   <= 3'h0;
      last_ff  <= 3'h0;
      b0_ff    <= 8'h00;
      b1_ff    <= 8'h00;
      b2_ff    <= 8'h00;
      pc_ff    <= `SSJE_PC_RESET;
      sp_ff    <= `SSJE_SP_RESET;
      addr_ff  <= 9'h000;
      bank0_ff <= 1'b0;
      rd_ff    <= 1'b0;
      wr_ff    <= 1'b0;
      wdat_ff  <= 8'h00;
      wwe_ff   <= 1'b0;
      wdout_ff <= 8'h00;
      psel_ff  <= 2'h0;
      done_ff  <= 1'b0;
      irq_ff   <= 1'b0;
      ill_ff   <= 1'b0;
    end else begin
      op_ff    <= nxt_op;
      cyc_ff   <= nxt_cyc;
      last_ff  <= nxt_last;
      b0_ff    <= nxt_b0;
      b1_ff    <= nxt_b1;
      b2_ff    <= nxt_b2;
      pc_ff    <= nxt_pc;
      sp_ff    <= nxt_sp;
      addr_ff  <= nxt_addr;
      bank0_ff <= nxt_bank0;
      rd_ff    <= nxt_rd;
      wr_ff    <= nxt_wr;
      wdat_ff  <= nxt_wdat;
      wwe_ff   <= nxt_wwe;
      wdout_ff <= nxt_wdout;
      psel_ff  <= nxt_psel;
      done_ff  <= nxt_done;
      irq_ff   <= nxt_irq;
      ill_ff   <= nxt_ill;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  // flags never written by this block
  assign flags_we                = 1'b0;
  assign data_addr               = addr_ff;
  assign data_bank0              = bank0_ff;
  assign data_rd_en              = rd_ff;
  assign data_wr_en              = wr_ff;
  assign data_wr                 = wdat_ff;
  assign work_reg_we             = wwe_ff;
  assign work_reg_out            = wdout_ff;
  assign indirect_pointer_select = psel_ff;
  assign program_counter         = pc_ff;
  assign stack_ptr               = sp_ff;
  assign busy                    = (op_ff != SSJE_NONE);
  assign done                    = done_ff;
  assign irq_window              = irq_ff;
  assign illegal_op              = ill_ff;

endmodule : ssje_exec

// ===== hw/ssje_map.svh
`ifndef SSJE_MAP_SVH
`define SSJE_MAP_SVH
// Opcodes and masks
`define SSJE_OP_PULL      8'h70
`define SSJE_MASK_PULL    8'hFE
`define SSJE_OP_SWAPD     8'hC2
`define SSJE_MASK_SWAPD   8'hFE
`define SSJE_OP_SWAPI     8'hC4
`define SSJE_MASK_SWAPI   8'hFC
`define SSJE_OP_NEAR      8'h28
`define SSJE_MASK_NEAR    8'hE8
`define SSJE_OP_FAR       8'h21
`define SSJE_OP_SHORT     8'h01
`define SSJE_OP_LONG      8'h11
// Field positions
`define SSJE_D8_BIT       0
`define SSJE_A11_BIT      4
// Program counter steps
`define SSJE_PC_STEP1     16'h0001
`define SSJE_PC_STEP2     16'h0002
`define SSJE_PC_STEP3     16'h0003
// Reset values
`define SSJE_PC_RESET     16'h0000
`define SSJE_SP_RESET     8'h00
// Cycle counts
`define SSJE_CYC_ONE      3'h1
`define SSJE_CYC_TWO      3'h2
`define SSJE_CYC_FOUR     3'h4
`endif

// ===== hw/ssje_pkg.sv
package ssje_pkg;
  typedef enum logic [3:0] {
    SSJE_NONE  = 4'b0000,
    SSJE_PULL  = 4'b0001,
    SSJE_SWAPD = 4'b0010,
    SSJE_SWAPI = 4'b0011,
    SSJE_NEAR  = 4'b0100,
    SSJE_FAR   = 4'b0101,
    SSJE_SHORT = 4'b0110,
    SSJE_LONG  = 4'b0111
  } ssje_op_e;
endpackage : ssje_pkg

// ===== test/ssje_data_mem.sv
// ****
// Data RAM with two banks
// ****
module ssje_data_mem (
  // Clock and bank choice
  input  wire logic       clk,
  input  wire logic       bank1_sel,
  // Access port
  input  wire logic       rd_en,
  input  wire logic       wr_en,
  input  wire logic       bank0,
  input  wire logic [8:0] addr,
  input  wire logic [7:0] wr,
  output logic [7:0]      rd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem0 [512];
  logic [7:0] mem1 [512];
  initial rd = 8'h00;
  // Read one cycle late; idle data toggles so stale bytes never look valid
  always @(posedge clk) begin
    if (rd_en) rd <= (bank1_sel && !bank0) ? mem1[addr] : mem0[addr];
    else rd <= ~rd;
    if (wr_en && bank1_sel && !bank0) mem1[addr] <= wr;
    else if (wr_en) mem0[addr] <= wr;
  end
endmodule : ssje_data_mem

// ===== test/ssje_exec_monitor.sv
// ****
// Decode and execute checker
// ****
module ssje_exec_monitor
  import ssje_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Request side
  input wire logic        start,
  input wire logic        busy,
  input wire logic [7:0]  instr_b0,
  input wire logic [7:0]  instr_b1,
  input wire logic [7:0]  instr_b2,
  input wire logic [8:0]  indirect_ptr_val,
  // Data side
  input wire logic [8:0]  data_addr,
  input wire logic        data_bank0,
  input wire logic        data_rd_en,
  input wire logic        data_wr_en,
  input wire logic        work_reg_we,
  input wire logic [1:0]  indirect_pointer_select,
  // State and status
  input wire logic [15:0] program_counter,
  input wire logic [7:0]  stack_ptr,
  input wire logic        done,
  input wire logic        irq_window,
  input wire logic        flags_we
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Take strobe and advanced counter, kept free of sampled functions
  logic        tk;
  logic [15:0] pc_p2;
  assign tk = start & ~busy;
  assign pc_p2 = program_counter + 16'h0002;
  pull_stack_read_a: assert property (tk && instr_b0[7:1] == 7'h38 |=>
    data_rd_en && data_bank0 && data_addr == {1'b0, $past(stack_ptr)})
    else $error("pull read bad");
  pull_write_back_a: assert property (tk && instr_b0[7:1] == 7'h38 |=> ##2
    data_wr_en && data_addr == {$past(instr_b0[0], 3), $past(instr_b1, 3)}
    && stack_ptr == $past(stack_ptr, 3) - 8'h01) else $error("pull write bad");
  two_cycle_irq_a: assert property (tk && (instr_b0[7:1] == 7'h38
    || instr_b0 == 8'h21 || (instr_b0 & 8'hE8) == 8'h28 || instr_b0 == 8'h01)
    |=> !irq_window [*2] ##1 (irq_window && done)) else $error("irq window bad");
  long_irq_hold_a: assert property (tk && instr_b0 == 8'h11 |=>
    !irq_window [*4] ##1 (irq_window && done)) else $error("long irq bad");
  far_target_a: assert property (tk && instr_b0 == 8'h21 |=> ##2
    program_counter == {$past(instr_b1, 3), $past(instr_b2, 3)}) else $error("far bad");
  near_target_a: assert property (tk && (instr_b0 & 8'hE8) == 8'h28 |=> ##2
    program_counter == {$past(pc_p2[15:12], 3), $past(instr_b0[4], 3), $past(instr_b0[2:0], 3),
    $past(instr_b1, 3)}) else $error("near bad");
  short_hop_a: assert property (tk && instr_b0 == 8'h01 |=> ##2
    program_counter == $past(pc_p2, 3) + {{8{$past(instr_b1[7], 3)}}, $past(instr_b1, 3)})
    else $error("short bad");
  long_hop_a: assert property (tk && instr_b0 == 8'h11 |=> ##4
    program_counter == $past(pc_p2, 5) + {$past(instr_b2, 5), $past(instr_b1, 5)})
    else $error("long bad");
  flags_quiet_a: assert property (!flags_we) else $error("flags written");
  swap_direct_a: assert property (tk && instr_b0[7:1] == 7'h61 |=> data_rd_en
    && data_addr == {$past(instr_b0[0]), $past(instr_b1)} ##2 (work_reg_we && data_wr_en && done))
    else $error("direct swap bad");
  swap_pointer_a: assert property (tk && instr_b0[7:2] == 6'h31 |=> data_addr ==
    $past(indirect_ptr_val) && indirect_pointer_select == $past(instr_b0[1:0]))
    else $error("pointer swap bad");
endmodule : ssje_exec_monitor

// ===== test/ssje_exec_tb.sv
// ****
// Bench top
// ****
module ssje_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ssje_pkg::*;
  logic        clk, reset, start, bank1_sel, data_bank0, data_rd_en, data_wr_en, work_reg_we;
  logic        busy, done, irq_window, flags_we, illegal_op, hit;
  logic [7:0]  instr_b0, instr_b1, instr_b2, work_reg_in, data_rd, data_wr, work_reg_out;
  logic [7:0]  stack_ptr, got_wr;
  logic [8:0]  indirect_ptr_val, data_addr;
  logic [1:0]  indirect_pointer_select;
  logic [15:0] program_counter;
  int          bad_count, n_checks, cycles;
  ssje_exec u_dut (.clk, .reset, .start, .instr_b0, .instr_b1, .instr_b2, .work_reg_in,
    .indirect_ptr_val, .data_rd, .data_addr, .data_bank0, .data_rd_en, .data_wr_en, .data_wr,
    .work_reg_we, .work_reg_out, .indirect_pointer_select, .program_counter, .stack_ptr, .busy,
    .done, .irq_window, .flags_we, .illegal_op);
  ssje_data_mem u_mem (.clk, .bank1_sel, .rd_en(data_rd_en), .wr_en(data_wr_en),
    .bank0(data_bank0), .addr(data_addr), .wr(data_wr), .rd(data_rd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One instruction; waits for done under a bound and checks its cycle count
  task automatic issue(input logic [7:0] b0, b1, b2, input int cyc);
    int n;
    {instr_b0, instr_b1, instr_b2, start, got_wr, n} = {b0, b1, b2, 1'b1, 8'hXX, 32'd0};
    @(posedge clk); #1;
    start = 1'b0;
    do begin
      @(posedge clk); #1;
      n++;
      if (work_reg_we === 1'b1) got_wr = work_reg_out;
    end while (done !== 1'b1 && n < 8);
    chk(16'(n), 16'(cyc));
    chk({15'h0, irq_window}, 16'h0001);
    // Final write lands one edge after done; let it reach memory first
    @(posedge clk); #1;
  endtask : issue
  task automatic t_pull;
    {bank1_sel, u_mem.mem0[0], u_mem.mem1[0], u_mem.mem0[255]} = {1'b1, 24'hA55A3C};
    issue(8'h71, 8'h23, 8'h00, 2);
    chk(u_mem.mem1[9'h123], 16'h00A5);
    chk(stack_ptr, 16'h00FF);
    issue(8'h70, 8'h45, 8'h00, 2);
    chk(u_mem.mem1[9'h045], 16'h003C);
    chk(program_counter, 16'h0004);
    $display("pull test finished");
  endtask : t_pull
  task automatic t_swap;
    {bank1_sel, u_mem.mem0[9'h110], work_reg_in} = {1'b0, 16'h77E1};
    issue(8'hC3, 8'h10, 8'h00, 2);
    chk(got_wr, 16'h0077);
    chk(u_mem.mem0[9'h110], 16'h00E1);
    for (int j = 0; j < 4; j++) begin
      {indirect_ptr_val, u_mem.mem0[64 + j]} = {9'(64 + j), 8'(j)};
      issue(8'(8'hC4 + j), 8'h00, 8'h00, 2);
      chk(got_wr, 16'(j));
      chk(u_mem.mem0[64 + j], 16'h00E1);
      chk(indirect_pointer_select, 16'(j));
    end
    chk(program_counter, 16'h000A);
    $display("swap test finished");
  endtask : t_swap
  task automatic t_jump;
    issue(8'h21, 8'h0F, 8'hFE, 2);
    chk(program_counter, 16'h0FFE);
    issue(8'h3F, 8'h0E, 8'h00, 2);
    chk(program_counter, 16'h1F0E);
    issue(8'h28, 8'h34, 8'h00, 2);
    chk(program_counter, 16'h1034);
    issue(8'h21, 8'h1F, 8'h13, 2);
    issue(8'h01, 8'hF9, 8'h00, 2);
    chk(program_counter, 16'h1F0E);
    issue(8'h21, 8'h0F, 8'h1E, 2);
    issue(8'h11, 8'h3F, 8'h01, 4);
    chk(program_counter, 16'h105F);
    issue(8'h21, 8'hFF, 8'hF0, 2);
    issue(8'h11, 8'h20, 8'h00, 4);
    chk(program_counter, 16'h0012);
    $display("jump test finished");
  endtask : t_jump
  // Start held while busy must be ignored; unknown opcode only flags
  task automatic t_refuse;
    {instr_b0, instr_b1, instr_b2, start} = {24'h21ABCD, 1'b1};
    @(posedge clk); #1;
    instr_b1 = 8'h55;
    @(posedge clk); #1;
    {instr_b0, hit} = {8'h00, 1'b0};
    // Start stays up until the unknown opcode is taken once the jump is done
    repeat (4) begin
      @(posedge clk); #1;
      hit = hit | illegal_op;
      start = start & ~hit;
    end
    chk({15'h0, hit}, 16'h0001);
    chk(program_counter, 16'hABCD);
    $display("refuse test finished");
  endtask : t_refuse
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard, far beyond the roughly 80 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    {reset, start, bank1_sel, instr_b0, instr_b1, instr_b2} = {3'b100, 24'h0};
    {work_reg_in, indirect_ptr_val} = 17'h0;
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    t_pull();
    t_swap();
    t_jump();
    t_refuse();
    close_out();
  end
endmodule : ssje_exec_tb
bind ssje_exec ssje_exec_monitor u_mon (.clk, .reset, .start, .busy, .instr_b0, .instr_b1,
  .instr_b2, .indirect_ptr_val, .data_addr, .data_bank0, .data_rd_en, .data_wr_en, .work_reg_we,
  .indirect_pointer_select, .program_counter, .stack_ptr, .done, .irq_window, .flags_we);
